/* File: rtl/ctf_framer.sv */
// Transmit framing sequencer with its Wishbone register file.
// Assumes one clock that stands for the carrier clock, a receiver on the
// same clock that pulses rx_end_i, and a classic Wishbone master.
//
// Functional notes
// - With grid alignment set, transmissions start only on ETU grid edges.
// - With grid alignment clear, a transmission may start at any clock.
// - Payload enable clear sends an unmodulated burst; set sends payload data.
// - Final byte bit count sets bits of last byte; zero means all eight.
// - Bits go LSB first; truncation drops the top bits of the byte.
// - Each Miller pulse lasts programmed width plus one carrier clock, unless the bit end comes first.
// - A pulse always ends by the end of its bit period.
// - Pulse start position comes from the modulation control setting.
// - Start and stop symbols use the same pulse width.
// - Burst level of the unmodulated burst comes from burst level control.
// - Burst length code selects 8 to 256 bits per the code table.
// - Guard time starts at end of transmit, or end of receive if set.
// - Guard unit is 16 carrier periods, or half an ETU if set.
// - Guard count is eleven bits: three upper bits and eight lower bits.
`include "ctf_map.svh"

module ctf_framer
  import ctf_pkg::*;
#(
  parameter int ETU_CLKS = `CTF_ETU_CARRIERS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire ctf_wb_req_t wb_req_i,
  input  wire logic        rx_end_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  output logic             mod_o,
  output logic             tx_active_o,
  output logic             guard_wait_o
);

  // ========================================================================
  // Decoding helpers
  // Burst length code to bit count; code 3 stands in for the 256-bit entry
  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    case (code)
      3'h0: burst_bits = 9'h008;
      3'h1: burst_bits = 9'h010;
      3'h2: burst_bits = 9'h020;
      3'h3: burst_bits = 9'h100;
      3'h4: burst_bits = 9'h030;
      3'h5: burst_bits = 9'h040;
      3'h6: burst_bits = 9'h060;
      default: burst_bits = 9'h080;
    endcase
  endfunction

  localparam logic [15:0] ETU_LAST = 16'(ETU_CLKS - 1);
  localparam logic [15:0] ETU_HALF = 16'(ETU_CLKS / 2);

  ctf_state_t  s;
  ctf_state_t  next_s;
  logic        hit;
  logic        wr;
  logic [7:0]  idx;
  logic        go;
  logic        bit_end;
  logic        in_pulse;
  logic        cur_bit;
  logic        end_tx;
  logic        miller;
  logic [15:0] pos;
  logic [15:0] rel;
  logic [10:0] guard_count;
  logic [23:0] guard_load;
  logic [3:0]  last_bits;

  // ========================================================================
  // Combinational decodes of the current state
  always_comb begin
    hit      = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
    wr       = hit & wb_req_i.we & wb_req_i.sel[0];
    idx      = wb_req_i.adr[9:2];
    miller   = s.mod_ctrl[`CTF_MILLER_BIT];
    pos      = s.mod_ctrl[`CTF_PULSE_POS_BIT] ? ETU_HALF : 16'h0000;
    rel      = s.ph - pos;
    // Width plus one; the phase wrap at bit end cuts it short
    in_pulse = (s.ph >= pos) && (rel <= {8'h00, s.pulse_width_clocks});
    bit_end  = (s.ph == ETU_LAST);
    cur_bit  = s.tx_data[s.bit_idx[4:0]];
    // Grid alignment waits for the free running ETU phase
    go       = (s.fsm == CTF_HOLD) && (s.guard == 24'h000000) &&
               (!s.last_grid[`CTF_GRID_BIT] || s.etu == 16'h0000);
    guard_count = {s.guard_ctrl[2:0], s.guard_time_lower};
    if (s.guard_ctrl[`CTF_GUARD_UNIT_BIT - 3]) begin
      guard_load = 24'(guard_count) * 24'(ETU_CLKS / 2);
    end else begin
      guard_load = 24'(guard_count) * 24'(`CTF_GUARD_CARRIERS);
    end
    // Zero in the last bit count means a full byte
    last_bits = (s.last_grid[2:0] == 3'h0) ? 4'h8 : {1'b0, s.last_grid[2:0]};
  end

  // ========================================================================
  // Next state
  always_comb begin
    next_s     = s;
    end_tx     = 1'b0;
    next_s.ack = hit;
    next_s.etu = (s.etu == ETU_LAST) ? 16'h0000 : s.etu + 16'h0001;
    if (s.guard != 24'h000000) begin
      next_s.guard = s.guard - 24'h000001;
    end

    // Sequencer
    case (s.fsm)
      CTF_IDLE: begin
        next_s.mod = 1'b0;
        if (s.pending) begin
          next_s.pending = 1'b0;
          next_s.fsm     = CTF_HOLD;
        end
      end
      CTF_HOLD: begin
        next_s.mod = 1'b0;
        if (go) begin
          next_s.ph      = 16'h0000;
          next_s.bit_idx = 9'h000;
          if (s.last_grid[`CTF_DATA_EN_BIT]) begin
            next_s.nbits = {4'h0, s.byte_count_m1, 3'h0} +
                           {5'h00, last_bits};
            next_s.fsm   = miller ? CTF_START_SYM : CTF_DATA;
          end else begin
            next_s.nbits = burst_bits(s.burst_bit_length);
            next_s.fsm   = CTF_BURST;
          end
        end
      end
      CTF_START_SYM: begin
        next_s.mod = in_pulse;
        next_s.ph  = bit_end ? 16'h0000 : s.ph + 16'h0001;
        if (bit_end) begin
          next_s.fsm = CTF_DATA;
        end
      end
      CTF_DATA: begin
        // Miller sends shaped pulses, otherwise the level of the bit
        next_s.mod = miller ? (cur_bit & in_pulse) : cur_bit;
        next_s.ph  = bit_end ? 16'h0000 : s.ph + 16'h0001;
        if (bit_end) begin
          if (s.bit_idx == s.nbits - 9'h001) begin
            if (miller) begin
              next_s.fsm = CTF_STOP_SYM;
            end else begin
              end_tx = 1'b1;
            end
          end else begin
            next_s.bit_idx = s.bit_idx + 9'h001;
          end
        end
      end
      CTF_STOP_SYM: begin
        next_s.mod = in_pulse;
        next_s.ph  = bit_end ? 16'h0000 : s.ph + 16'h0001;
        end_tx     = bit_end;
      end
      CTF_BURST: begin
        next_s.mod = s.mod_ctrl[`CTF_BURST_LVL_BIT];
        next_s.ph  = bit_end ? 16'h0000 : s.ph + 16'h0001;
        if (bit_end) begin
          if (s.bit_idx == s.nbits - 9'h001) begin
            end_tx = 1'b1;
          end else begin
            next_s.bit_idx = s.bit_idx + 9'h001;
          end
        end
      end
      default: begin
        next_s.fsm = CTF_IDLE;
      end
    endcase

    // End of a transmission, and guard start point
    if (end_tx) begin
      next_s.fsm = CTF_IDLE;
      if (!s.guard_ctrl[`CTF_GUARD_REF_BIT - 3]) begin
        next_s.guard = guard_load;
      end
    end
    if (rx_end_i && s.guard_ctrl[`CTF_GUARD_REF_BIT - 3]) begin
      next_s.guard = guard_load;
    end

    // Register reads; unmapped addresses read zero
    next_s.rdat = 32'h00000000;
    if (idx == `CTF_IDX_LAST_GRID) begin
      next_s.rdat[4:0] = s.last_grid;
    end else if (idx == `CTF_IDX_PULSE_WIDTH) begin
      next_s.rdat[7:0] = s.pulse_width_clocks;
    end else if (idx == `CTF_IDX_BURST_LEN) begin
      next_s.rdat[6:4] = s.burst_bit_length;
    end else if (idx == `CTF_IDX_GUARD_CTRL) begin
      next_s.rdat[7:3] = s.guard_ctrl;
    end else if (idx == `CTF_IDX_GUARD_LOW) begin
      next_s.rdat[7:0] = s.guard_time_lower;
    end else if (idx == `CTF_IDX_MOD_CTRL) begin
      next_s.rdat[2:0] = s.mod_ctrl;
    end else if (idx == `CTF_IDX_TX_DATA) begin
      next_s.rdat = s.tx_data;
    end else if (idx == `CTF_IDX_TX_CMD) begin
      next_s.rdat[4:0] = {s.guard_wait, s.active, s.pending, s.byte_count_m1};
    end
    if (!hit || wb_req_i.we) begin
      next_s.rdat = 32'h00000000;
    end

    // Register writes; a start write wins over the sequencer's clear
    if (wr) begin
      if (idx == `CTF_IDX_LAST_GRID) begin
        next_s.last_grid = wb_req_i.dat[4:0];
      end else if (idx == `CTF_IDX_PULSE_WIDTH) begin
        next_s.pulse_width_clocks = wb_req_i.dat[7:0];
      end else if (idx == `CTF_IDX_BURST_LEN) begin
        next_s.burst_bit_length = wb_req_i.dat[6:4];
      end else if (idx == `CTF_IDX_GUARD_CTRL) begin
        next_s.guard_ctrl = wb_req_i.dat[7:3];
      end else if (idx == `CTF_IDX_GUARD_LOW) begin
        next_s.guard_time_lower = wb_req_i.dat[7:0];
      end else if (idx == `CTF_IDX_MOD_CTRL) begin
        next_s.mod_ctrl = wb_req_i.dat[2:0];
      end else if (idx == `CTF_IDX_TX_CMD) begin
        next_s.byte_count_m1 = wb_req_i.dat[1:0];
        if (wb_req_i.dat[`CTF_START_BIT]) begin
          next_s.pending = 1'b1;
        end
      end
    end
    // Payload word honours every byte lane
    if (hit && wb_req_i.we && idx == `CTF_IDX_TX_DATA) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_req_i.sel[b]) begin
          next_s.tx_data[8*b +: 8] = wb_req_i.dat[8*b +: 8];
        end
      end
    end

    next_s.active     = (next_s.fsm != CTF_IDLE) && (next_s.fsm != CTF_HOLD);
    next_s.guard_wait = (next_s.guard != 24'h000000);
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s                    <= '0;
      s.fsm                <= CTF_IDLE;
      s.guard_ctrl         <= 5'(`CTF_RST_GUARD_CTRL >> 3);
      s.pulse_width_clocks <= `CTF_RST_ZERO8;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register
  assign wb_ack_o     = s.ack;
  assign wb_dat_o     = s.rdat;
  assign mod_o        = s.mod;
  assign tx_active_o  = s.active;
  assign guard_wait_o = s.guard_wait;

  // ========================================================================
  // Checks
  logic [15:0] mod_len;

  // Length of the current run of modulation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_len <= 16'h0000;
    end else if (next_s.mod) begin
      // Each bit period counts its own pulse, so touching pulses stay apart
      if (s.ph == 16'h0000) begin
        mod_len <= 16'h0001;
      end else begin
        mod_len <= mod_len + 16'h0001;
      end
    end else begin
      mod_len <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_grid_start: assert property (
    $rose(s.active) && $past(s.last_grid[`CTF_GRID_BIT]) |->
    s.etu == 16'h0001)
    else $error("start off the ETU grid");
  a_guard_holdoff: assert property (
    (s.fsm == CTF_HOLD && s.guard != 24'h000000) |=> !s.active)
    else $error("transmission began inside the guard time");
  a_mode_select: assert property (
    go |=> (s.fsm == CTF_BURST) == !$past(s.last_grid[`CTF_DATA_EN_BIT]))
    else $error("wrong pattern selected for payload enable");
  a_bit_count: assert property (
    s.fsm == CTF_DATA |-> s.bit_idx < s.nbits)
    else $error("more bits sent than the final byte allows");
  a_pulse_width: assert property (
    (miller && s.fsm inside {CTF_START_SYM, CTF_STOP_SYM}) |->
    mod_len <= {8'h00, s.pulse_width_clocks} + 16'h0001)
    else $error("symbol pulse longer than width plus one");
  a_pulse_clip: assert property (
    miller && s.fsm != CTF_BURST |-> mod_len <= 16'(ETU_CLKS))
    else $error("pulse runs past its bit period");
  a_burst_level: assert property (
    s.fsm == CTF_BURST |=> s.mod == $past(s.mod_ctrl[`CTF_BURST_LVL_BIT]))
    else $error("burst level differs from control");
  a_nrz_level: assert property (
    (!miller && s.fsm == CTF_DATA) |=> s.mod == $past(cur_bit))
    else $error("non-Miller bit level not sent");
  a_guard_load: assert property (
    end_tx && !s.guard_ctrl[`CTF_GUARD_REF_BIT - 3] |=>
    s.guard == $past(guard_load))
    else $error("guard not started at end of transmit");
  a_wb_answer: assert property (
    hit |=> s.ack ##1 !s.ack)
    else $error("bus answer not a single cycle");

  a_guard_reply: assert property (
    rx_end_i && s.guard_ctrl[`CTF_GUARD_REF_BIT - 3] |=>
    s.guard == $past(guard_load))
    else $error("guard not started at end of receive");
  a_pulse_start: assert property (
    (miller && s.fsm inside {CTF_START_SYM, CTF_STOP_SYM} && s.ph < pos)
    |=> !s.mod)
    else $error("symbol pulse began before its start position");
  a_symbol_pulse: assert property (
    (miller && s.fsm inside {CTF_START_SYM, CTF_STOP_SYM} && s.ph == pos)
    |=> s.mod)
    else $error("symbol pulse missing at its start position");

  // Main scenarios
  c_burst_sent: cover property (s.fsm == CTF_BURST ##1 s.fsm == CTF_IDLE);
  c_truncated: cover property (end_tx && s.last_grid[2:0] != 3'h0);
  c_grid_start: cover property (go && s.last_grid[`CTF_GRID_BIT]);
  c_rx_guard: cover property (rx_end_i && s.guard_ctrl[`CTF_GUARD_REF_BIT - 3]);
  c_miller_end: cover property (s.fsm == CTF_STOP_SYM ##1 s.fsm == CTF_IDLE);

endmodule

/* File: rtl/ctf_map.svh */
// Register indices, field positions, reset values and timing counts of
// the transmit framing block.
// Assumes the includer reads registers at byte address four times index.
`ifndef CTF_MAP_SVH
`define CTF_MAP_SVH

// ==========================================================================
// Register indices (byte address is index times four)
`define CTF_IDX_LAST_GRID   8'h2E
`define CTF_IDX_PULSE_WIDTH 8'h2F
`define CTF_IDX_BURST_LEN   8'h30
`define CTF_IDX_GUARD_CTRL  8'h31
`define CTF_IDX_GUARD_LOW   8'h32
`define CTF_IDX_MOD_CTRL    8'h40
`define CTF_IDX_TX_DATA     8'h41
`define CTF_IDX_TX_CMD      8'h42

// ==========================================================================
// Field positions
`define CTF_GRID_BIT        4
`define CTF_DATA_EN_BIT     3
`define CTF_MILLER_BIT      0
`define CTF_PULSE_POS_BIT   1
`define CTF_BURST_LVL_BIT   2
`define CTF_GUARD_REF_BIT   7
`define CTF_GUARD_UNIT_BIT  6
`define CTF_START_BIT       7

// ==========================================================================
// Reset values
`define CTF_RST_GUARD_CTRL  8'hC0
`define CTF_RST_ZERO8       8'h00

// ==========================================================================
// Timing: carrier periods per carrier based guard unit, and per ETU
`define CTF_GUARD_CARRIERS  16
`define CTF_ETU_CARRIERS    128

`endif

/* File: rtl/ctf_pkg.sv */
// Types of the transmit framing block.
// Assumes ctf_map.svh is compiled alongside.
package ctf_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    CTF_IDLE,
    CTF_HOLD,
    CTF_START_SYM,
    CTF_DATA,
    CTF_STOP_SYM,
    CTF_BURST
  } ctf_fsm_t;

  // ========================================================================
  // Classic Wishbone request from the bus master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ctf_wb_req_t;

  // ========================================================================
  // Whole state of the framer
  typedef struct packed {
    ctf_fsm_t    fsm;
    logic [4:0]  last_grid;
    logic [7:0]  pulse_width_clocks;
    logic [2:0]  burst_bit_length;
    logic [4:0]  guard_ctrl;
    logic [7:0]  guard_time_lower;
    logic [2:0]  mod_ctrl;
    logic [31:0] tx_data;
    logic [1:0]  byte_count_m1;
    logic        pending;
    logic [15:0] etu;
    logic [15:0] ph;
    logic [8:0]  bit_idx;
    logic [8:0]  nbits;
    logic [23:0] guard;
    logic        mod;
    logic        active;
    logic        guard_wait;
    logic        ack;
    logic [31:0] rdat;
  } ctf_state_t;

endpackage

/* File: verif/ctf_card_model.sv */
// Card model that listens to the reader envelope on the far side.
// Assumes mod_i is the registered envelope on the same clock.
module ctf_card_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       mod_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] reply_gap_i,
  output logic            rx_end_o,
  output logic [7:0]      n_pulse_o,
  output logic [7:0]      max_w_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] w_q;
  logic [7:0] quiet_q;
  logic       heard_q;

  // ==========================================================================
  // Pulse log, and a reply once the line has been quiet long enough
  always_ff @(posedge clk_i) begin
    rx_end_o <= 1'b0;
    if (rst_i || clr_i) begin
      w_q       <= 8'h00;
      n_pulse_o <= 8'h00;
      max_w_o   <= 8'h00;
      quiet_q   <= 8'h00;
      heard_q   <= 1'b0;
    end else if (mod_i) begin
      w_q     <= w_q + 8'h01;
      quiet_q <= 8'h00;
      heard_q <= 1'b1;
    end else begin
      if (w_q != 8'h00) begin
        n_pulse_o <= n_pulse_o + 8'h01;
        if (w_q > max_w_o) max_w_o <= w_q;
      end
      w_q <= 8'h00;
      if (heard_q) quiet_q <= quiet_q + 8'h01;
      // Slow replies come from a larger gap
      if (heard_q && quiet_q == reply_gap_i) begin
        rx_end_o <= 1'b1;
        heard_q  <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/tb_ctf_framer.sv */
// Bench of the transmit framer: registers, frame shape, bursts, grid, guard.
// Assumes a one-cycle ack per bus request and a card model on mod_o.
module tb_ctf_framer
  import ctf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ETU = 8;

  logic        clk_i;
  logic        rst_i;
  ctf_wb_req_t wb_req;
  logic        rx_end, wb_ack, mod, active, clr, gw;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  logic [7:0]  gap, n_pulse, max_w;
  logic [15:0] bits;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          t_rise, t_prev, t_fall, len;
  logic [7:0]  ridx [4] = '{8'h2E, 8'h2F, 8'h30, 8'h31};
  logic [31:0] rexp [4] = '{32'h1F, 32'hFF, 32'h70, 32'hF8};
  int          blen [8] = '{8, 16, 32, 256, 48, 64, 96, 128};

  ctf_framer #(.ETU_CLKS(ETU)) i_ctf_framer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .rx_end_i(rx_end),
    .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .mod_o(mod),
    .tx_active_o(active), .guard_wait_o(gw));
  ctf_card_model i_ctf_card_model (
    .clk_i(clk_i), .rst_i(rst_i), .mod_i(mod), .clr_i(clr),
    .reply_gap_i(gap), .rx_end_o(rx_end), .n_pulse_o(n_pulse),
    .max_w_o(max_w));

  // ==========================================================================
  // Clock, cycle count and hang guard
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // ==========================================================================
  // Verdict and comparisons
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    checks = checks + 1;
    if (got < lo || got > hi) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // Classic Wishbone cycle; ack and read data are taken at a rising edge
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:{idx, 2'b00},
                sel:4'hF, dat:wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    rng(n, 2, 2);
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // ==========================================================================
  // Start a frame, time it and sample the envelope mid-bit
  task automatic frame(input logic [1:0] bm1);
    int n;
    n = 0;
    wr(8'h42, {24'h0, 1'b1, 5'h0, bm1});
    while (active !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    t_prev = t_rise;
    t_rise = cyc_n;
    n = 0;
    while (active === 1'b1) begin
      if (n % ETU == ETU / 2 && n / ETU < 16) bits[n / ETU] = mod;
      @(negedge clk_i);
      n++;
    end
    len = n;
    t_fall = cyc_n;
  endtask
  task automatic miller(input logic [7:0] w);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    frame(2'h0);
    repeat (ETU) @(posedge clk_i);
    chk({24'h0, n_pulse}, 32'h3);
    chk({24'h0, max_w}, {24'h0, w});
  endtask
  task automatic gchk(input int g);
    int tf;
    frame(2'h0);
    tf = t_fall;
    chk({31'h0, gw}, 32'h1);
    frame(2'h0);
    rng(t_rise - tf, g, g + 6);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    int off;
    wb_req = '0;
    rst_i  = 1'b1;
    clr    = 1'b0;
    gap    = 8'h28;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h31, 32'hC0);
    foreach (ridx[i]) begin
      wr(ridx[i], 32'hFF);
      rdc(ridx[i], rexp[i]);
    end
    wr(8'h10, 32'hFF);
    rdc(8'h10, 32'h0);
    wr(8'h31, 32'h0);
    wr(8'h32, 32'h0);
    // Plain level coding with a truncated second byte
    wr(8'h40, 32'h0);
    wr(8'h2F, 32'h05);
    wr(8'h41, 32'hB2A5);
    wr(8'h2E, 32'h0E);
    frame(2'h1);
    chk(32'(len), 32'(14 * ETU));
    chk({18'h0, bits[13:0]}, 32'h32A5);
    wr(8'h2E, 32'h08);
    frame(2'h0);
    chk(32'(len), 32'(8 * ETU));
    chk({24'h0, bits[7:0]}, 32'hA5);
    // Miller pulses, then clipped at the bit end from mid-bit
    wr(8'h40, 32'h1);
    wr(8'h2F, 32'h02);
    wr(8'h41, 32'h01);
    wr(8'h2E, 32'h09);
    miller(8'h03);
    wr(8'h40, 32'h3);
    wr(8'h2F, 32'h14);
    miller(8'(ETU / 2));
    // Guard counted from the card's reply
    wr(8'h32, 32'h04);
    wr(8'h31, 32'h80);
    frame(2'h0);
    n = 0;
    while (rx_end !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    n = cyc_n;
    frame(2'h0);
    rng(t_rise - n, 4 * 16, 4 * 16 + 6);
    // Every burst length code, each with one level taken from the code's low bit
    wr(8'h31, 32'h0);
    wr(8'h2E, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h30, 32'(c) << 4);
      wr(8'h40, {29'h0, c[0], 2'h0});
      frame(2'h0);
      chk(32'(len), 32'(blen[c] * ETU));
      chk({31'h0, bits[0]}, {31'h0, c[0]});
    end
    // Start spacing with and without the ETU grid
    wr(8'h32, 32'h0);
    wr(8'h40, 32'h0);
    wr(8'h30, 32'h0);
    off = 0;
    for (int g = 1; g >= 0; g--) begin
      wr(8'h2E, 32'(g) << 4);
      for (int d = 1; d < 4; d++) begin
        frame(2'h0);
        repeat (d) @(posedge clk_i);
        frame(2'h0);
        if (g == 1) chk(32'((t_rise - t_prev) % ETU), 32'h0);
        else off = off | int'((t_rise - t_prev) % ETU != 0);
      end
    end
    chk(32'(off), 32'h1);
    // Guard from end of transmit in both units
    wr(8'h2E, 32'h0);
    wr(8'h31, 32'h48);
    gchk(256 * ETU / 2);
    wr(8'h31, 32'h0);
    wr(8'h32, 32'h04);
    gchk(4 * 16);
    complete_run();
  end
endmodule
